// ==== bench/bad_chk.sv ====
// Port checker for the byte add-with-carry decode and execute block
module bad_chk (
  // Clock and control
  input logic        sys_clk_in,
  input logic        reset_in,
  input logic        clk_en_in,
  input logic        acc_load_in,
  // Observed outputs and the memory read valid
  input logic        byte_ready_out,
  input logic        mem_rd_req_out,
  input logic [15:0] mem_addr_out,
  input logic        mem_rd_valid_in,
  input logic [7:0]  acc_out,
  input logic [7:0]  flags_out,
  input logic        done_out,
  input logic        no_match_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  // ----------
  // Assertions
  // ----------
  a_sign_flag: assert property (
    done_out |-> flags_out[7] == acc_out[7])
    else $error("sign flag differs from result bit");
  a_zero_flag: assert property (
    done_out |-> flags_out[6] == (acc_out == 8'h00))
    else $error("zero flag differs from result");
  a_sub_clear: assert property (done_out |-> !flags_out[1])
    else $error("subtract flag set after add");
  a_acc_cause: assert property (
    $changed(acc_out) |-> done_out || $past(acc_load_in))
    else $error("accumulator changed without cause");
  a_done_pulse: assert property (done_out && clk_en_in |=> !done_out)
    else $error("done longer than one cycle");
  a_one_answer: assert property (!(done_out && no_match_out))
    else $error("done and reject together");
  a_no_trap: assert property (
    no_match_out |-> $stable(acc_out) && $stable(flags_out))
    else $error("rejected sequence altered state");
  a_req_holds: assert property (
    mem_rd_req_out && !mem_rd_valid_in && clk_en_in
      |=> mem_rd_req_out && $stable(mem_addr_out))
    else $error("read request dropped or moved");
  a_wait_refuse: assert property (mem_rd_req_out |-> !byte_ready_out)
    else $error("byte accepted while reading");
  a_read_done: assert property (
    mem_rd_req_out && mem_rd_valid_in && clk_en_in |-> ##[1:3] done_out)
    else $error("no result after operand read");

  c_done: cover property (done_out);
  c_reject: cover property (no_match_out);
  c_slow_mem: cover property (mem_rd_req_out ##1 mem_rd_req_out);
endmodule

bind bad_decode_exec bad_chk u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .acc_load_in(acc_load_in), .byte_ready_out(byte_ready_out),
  .mem_rd_req_out(mem_rd_req_out), .mem_addr_out(mem_addr_out),
  .mem_rd_valid_in(mem_rd_valid_in), .acc_out(acc_out),
  .flags_out(flags_out), .done_out(done_out), .no_match_out(no_match_out)
);

// ==== bench/bad_mem_model.sv ====
// Operand memory model answering the block's read requests
module bad_mem_model (
  // Clock, request and answer delay
  input  logic        sys_clk_in,
  input  logic        mem_rd_req_in,
  input  logic [15:0] mem_addr_in,
  input  logic [3:0]  delay_in,
  // Answer
  output logic        mem_rd_valid_out,
  output logic [7:0]  mem_rd_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q = 4'h0;

  initial begin
    mem_rd_valid_out = 1'b0;
    mem_rd_data_out = 8'h00;
  end

  // Data is inverted every cycle between answers, so a stale byte matches the last answer only on every second cycle
  always @(posedge sys_clk_in) begin
    mem_rd_valid_out <= 1'b0;
    mem_rd_data_out <= ~mem_rd_data_out;
    if (!mem_rd_req_in || mem_rd_valid_out) begin
      wait_q <= delay_in;
    end else if (wait_q == 4'h0) begin
      mem_rd_valid_out <= 1'b1;
      mem_rd_data_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ 8'h3c;
    end else begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule

// ==== bench/bad_tb.sv ====
// Self-checking bench for the byte add-with-carry decode and execute block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, vld, rdy, ld, req, mv, done, nm;
  logic [7:0]  bin, la, lf, md, acc, flg, acc_m, flg_m;
  logic [47:0] gpr;
  logic [15:0] ix1, ix2, sp, pc, addr;
  logic [15:0] rs = 16'hdae7;
  logic [3:0]  dly;
  logic        en = 1'b1;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  bad_decode_exec uut (
    .sys_clk_in(clk), .reset_in(rst), .clk_en_in(en),
    .byte_valid_in(vld), .byte_in(bin), .byte_ready_out(rdy),
    .gpr_in(gpr), .first_index_reg_in(ix1), .second_index_reg_in(ix2),
    .stack_pointer_in(sp), .pc_in(pc), .acc_load_in(ld),
    .acc_load_data_in(la), .flags_load_data_in(lf),
    .mem_rd_req_out(req), .mem_addr_out(addr), .mem_rd_valid_in(mv),
    .mem_rd_data_in(md), .acc_out(acc), .flags_out(flg),
    .done_out(done), .no_match_out(nm));
  bad_mem_model u_mem (
    .sys_clk_in(clk), .mem_rd_req_in(req), .mem_addr_in(addr),
    .delay_in(dly), .mem_rd_valid_out(mv), .mem_rd_data_out(md));

  // ----------
  // Helpers
  // ----------
  function automatic logic [15:0] rnd();
    rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
    return rs;
  endfunction

  function automatic logic [15:0] adc(input logic [7:0] a, s, f);
    logic [8:0] r;
    logic [7:0] o;
    r = a + s + f[0];
    o = f & 8'h28;
    o[7] = r[7];
    o[6] = (r[7:0] == 8'h00);
    o[4] = (a[3:0] + s[3:0] + f[0]) > 5'h0f;
    o[2] = (a[7] == s[7]) && (r[7] != a[7]);
    o[0] = r[8];
    return {o, r[7:0]};
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One instruction: mode m, optional load of a and f, immediate data s
  task automatic run(input logic [3:0] m, input logic ldn,
                     input logic [7:0] a, f, s);
    logic [7:0]  q[$];
    logic [47:0] g;
    logic [15:0] x1, x2, spv, pcv, ad, d, x, e;
    logic [7:0]  src, av, fv;
    logic [2:0]  r;
    logic [1:0]  xs;
    logic        pf, bad;
    int          n;
    g = {rnd(), rnd(), rnd()};
    x1 = rnd();
    x2 = rnd();
    spv = rnd();
    pcv = rnd();
    d = rnd();
    gpr <= g;
    ix1 <= x1;
    ix2 <= x2;
    sp <= spv;
    pc <= pcv;
    dly <= {1'b0, d[10:8]};
    r = (d[2:0] == 3'h6) ? 3'h7 : d[2:0];
    xs = (d[5:4] == 2'h0) ? 2'h1 : d[5:4];
    pf = d[3];
    x = pf ? x2 : x1;
    av = ldn ? a : acc_m;
    fv = ldn ? f : flg_m;
    bad = 1'b0;
    src = s;
    ad = 16'h0000;
    case (m)
      0: begin
        q = '{8'h88 | r};
        src = (r == 3'h7) ? av : g[47 - 8 * r -: 8];
      end
      1: begin
        q = '{pf ? 8'hfd : 8'hdd, 8'h8c | d[4]};
        src = d[4] ? x[7:0] : x[15:8];
      end
      2: q = '{8'hce, s};
      3: ad = g[15:0];
      4: begin
        q = '{8'hdd, 8'h8f, d[7:0], d[15:8]};
        ad = d;
      end
      5: begin
        q = '{8'hfd, 8'h88 | xs, d[7:0], d[15:8]};
        ad = d + (xs == 2'h1 ? x1 : xs == 2'h2 ? x2 : g[15:0]);
      end
      6: begin
        q = '{pf ? 8'hfd : 8'hdd, 8'h8e, d[7:0]};
        ad = x + {{8{d[7]}}, d[7:0]};
      end
      7: begin
        q = '{8'hfd, 8'h88, d[7:0], d[15:8]};
        ad = pcv + d;
      end
      8: begin
        q = '{8'hdd, 8'h88, d[7:0], d[15:8]};
        ad = spv + d;
      end
      9: begin
        q = '{8'hdd, 8'h88 | xs};
        ad = xs == 2'h1 ? g[15:0] + x1 : xs == 2'h2 ? g[15:0] + x2 : x1 + x2;
      end
      default: begin
        bad = 1'b1;
        if (pf) q = '{8'h00};
        else if (d[6]) q = '{8'hdd, 8'hce};
        else q = '{8'hfd, 8'h8f};
      end
    endcase
    if (m == 3) q = '{8'h8e};
    if (m >= 3 && m <= 9) src = ad[7:0] ^ ad[15:8] ^ 8'h3c;
    if (ldn) begin
      ld <= 1'b1;
      la <= a;
      lf <= f;
      @(posedge clk);
      ld <= 1'b0;
    end
    foreach (q[i]) begin
      vld <= 1'b1;
      bin <= q[i];
      do @(posedge clk); while (rdy !== 1'b1);
    end
    vld <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && nm !== 1'b1 && n < 60);
    e = adc(av, src, fv);
    acc_m = bad ? av : e[7:0];
    flg_m = bad ? fv : e[15:8];
    cmp({7'h00, done}, {7'h00, !bad});
    cmp({7'h00, nm}, {7'h00, bad});
    cmp(acc, acc_m);
    cmp(flg, flg_m);
  endtask

  // ----------
  // Run
  // ----------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cut a hang short; a full run needs well under a third of this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    logic [15:0] t, u;
    {rst, vld, ld} = 3'h4;
    {bin, la, lf, gpr} = 72'h0;
    {ix1, ix2, sp, pc, dly} = {64'h0, 4'h0};
    acc_m = 8'h00;
    flg_m = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cmp(acc, 8'h00);
    cmp(flg, 8'h00);
    repeat (2) @(posedge clk);
    run(4'h2, 1'b1, 8'h7f, 8'h01, 8'h00);
    run(4'h2, 1'b1, 8'hff, 8'h01, 8'h00);
    run(4'h2, 1'b1, 8'h0f, 8'hff, 8'h70);
    for (int k = 0; k < 11; k++) begin
      run(k[3:0], 1'b1, 8'h80, 8'h00, 8'h80);
    end
    // A load offered while the enable is low must not land
    en <= 1'b0;
    ld <= 1'b1;
    la <= ~acc_m;
    lf <= ~flg_m;
    repeat (3) @(posedge clk);
    cmp(acc, acc_m);
    cmp(flg, flg_m);
    ld <= 1'b0;
    en <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 300; k++) begin
      t = rnd();
      u = rnd();
      run(t[3:0] % 4'hb, t[4], u[7:0], u[15:8], t[15:8]);
    end
    test_done();
  end
endmodule

// ==== design/bad_consts.vh ====
// Constants for the byte add-with-carry decode and execute block
`ifndef BAD_CONSTS_VH
`define BAD_CONSTS_VH

// ----------------------------------------------------------------
// Register field codes
// ----------------------------------------------------------------
`define BAD_REG_A        3'h7
`define BAD_REG_B        3'h0
`define BAD_REG_C        3'h1
`define BAD_REG_D        3'h2
`define BAD_REG_E        3'h3
`define BAD_REG_H        3'h4
`define BAD_REG_L        3'h5

// ----------------------------------------------------------------
// Opcode bytes and fields
// ----------------------------------------------------------------
`define BAD_OPC_MAIN     5'h11
`define BAD_OPC_IMM      8'hce
`define BAD_PFX_FIRST    8'hdd
`define BAD_PFX_SECOND   8'hfd
`define BAD_PFX_SEL_BIT  5
`define BAD_FLD_MEM      3'h6
`define BAD_FLD_DIRECT   3'h7
`define BAD_FLD_REL      3'h0
`define BAD_FLD_RX_HI    3'h4
`define BAD_FLD_RX_LO    3'h5
`define BAD_SEL_FIRST    3'h1
`define BAD_SEL_SECOND   3'h2
`define BAD_SEL_PAIR     3'h3

// ----------------------------------------------------------------
// Flag bit positions and reset values
// ----------------------------------------------------------------
`define BAD_FLG_S        7
`define BAD_FLG_Z        6
`define BAD_FLG_H        4
`define BAD_FLG_V        2
`define BAD_FLG_N        1
`define BAD_FLG_C        0
`define BAD_ACC_RST      8'h00
`define BAD_FLG_RST      8'h00
`define BAD_ADDR_RST     16'h0000

`endif

// ==== design/bad_decode_exec.v ====
// Decode and execute of the byte add-with-carry to accumulator
`include "bad_consts.vh"

module bad_decode_exec (
  // Clock, reset, enable
  input  wire        sys_clk_in,
  input  wire        reset_in,
  input  wire        clk_en_in,
  // Instruction byte stream from fetch
  input  wire        byte_valid_in,
  input  wire [7:0]  byte_in,
  output wire        byte_ready_out,
  // Core register values
  input  wire [47:0] gpr_in,
  input  wire [15:0] first_index_reg_in,
  input  wire [15:0] second_index_reg_in,
  input  wire [15:0] stack_pointer_in,
  input  wire [15:0] pc_in,
  // Accumulator and flag load from the core
  input  wire        acc_load_in,
  input  wire [7:0]  acc_load_data_in,
  input  wire [7:0]  flags_load_data_in,
  // Operand memory read
  output wire        mem_rd_req_out,
  output wire [15:0] mem_addr_out,
  input  wire        mem_rd_valid_in,
  input  wire [7:0]  mem_rd_data_in,
  // Results and status
  output wire [7:0]  acc_out,
  output wire [7:0]  flags_out,
  output wire        done_out,
  output wire        no_match_out
);

  // ----------------------------------------------------------------
  // States and modes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_PREFIX = 3'h1;
  localparam [2:0] ST_OPER1  = 3'h2;
  localparam [2:0] ST_OPER2  = 3'h3;
  localparam [2:0] ST_ADDR   = 3'h4;
  localparam [2:0] ST_WAIT   = 3'h5;
  localparam [2:0] ST_EXEC   = 3'h6;

  localparam [3:0] MD_REG    = 4'h0;
  localparam [3:0] MD_IMM    = 4'h1;
  localparam [3:0] MD_IND    = 4'h2;
  localparam [3:0] MD_DIRECT = 4'h3;
  localparam [3:0] MD_INDEX  = 4'h4;
  localparam [3:0] MD_SHORT  = 4'h5;
  localparam [3:0] MD_PCREL  = 4'h6;
  localparam [3:0] MD_STACK  = 4'h7;
  localparam [3:0] MD_BASE   = 4'h8;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  reg [2:0]  state_q, state_d;
  reg [3:0]  mode_q, mode_d;
  reg        pfx_q, pfx_d;
  reg [2:0]  field_q, field_d;
  reg [7:0]  lo_q, lo_d;
  reg [7:0]  hi_q, hi_d;
  reg [7:0]  opnd_q, opnd_d;
  reg [7:0]  acc_q, acc_d;
  reg [7:0]  flg_q, flg_d;
  reg        req_q, req_d;
  reg [15:0] addr_q, addr_d;
  reg        done_q, done_d;
  reg        nomatch_q, nomatch_d;
  reg        ready_q;

  wire       take;
  wire [15:0] hl_pair;
  wire [15:0] disp16;
  wire [15:0] disp8;
  wire [15:0] sel_index;
  reg  [15:0] ea;
  reg  [7:0]  reg_val;
  reg  [8:0]  sum9;
  reg  [4:0]  sum5;
  reg  [7:0]  res;

  assign take      = byte_valid_in & ready_q;
  assign hl_pair   = gpr_in[15:0];
  assign disp16    = {hi_q, lo_q};
  assign disp8     = {{8{lo_q[7]}}, lo_q};
  assign sel_index = pfx_q ? second_index_reg_in : first_index_reg_in;

  // ----------------------------------------------------------------
  // Register field select
  // ----------------------------------------------------------------
  always @* begin
    case (byte_in[2:0])
      `BAD_REG_A: reg_val = acc_q;
      `BAD_REG_B: reg_val = gpr_in[47:40];
      `BAD_REG_C: reg_val = gpr_in[39:32];
      `BAD_REG_D: reg_val = gpr_in[31:24];
      `BAD_REG_E: reg_val = gpr_in[23:16];
      `BAD_REG_H: reg_val = gpr_in[15:8];
      `BAD_REG_L: reg_val = gpr_in[7:0];
      default:    reg_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Effective address of a memory operand
  // ----------------------------------------------------------------
  always @* begin
    case (mode_q)
      MD_IND:    ea = hl_pair;
      MD_DIRECT: ea = disp16;
      MD_SHORT:  ea = sel_index + disp8;
      MD_PCREL:  ea = pc_in + disp16;
      MD_STACK:  ea = stack_pointer_in + disp16;
      MD_INDEX: begin
        case (field_q)
          `BAD_SEL_FIRST:  ea = first_index_reg_in + disp16;
          `BAD_SEL_SECOND: ea = second_index_reg_in + disp16;
          default:         ea = hl_pair + disp16;
        endcase
      end
      MD_BASE: begin
        case (field_q)
          `BAD_SEL_FIRST:  ea = hl_pair + first_index_reg_in;
          `BAD_SEL_SECOND: ea = hl_pair + second_index_reg_in;
          default: ea = first_index_reg_in + second_index_reg_in;
        endcase
      end
      default:   ea = `BAD_ADDR_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // Adder and flags
  // ----------------------------------------------------------------
  // Carry in is the flag as it stands before this instruction
  always @* begin
    sum9 = {1'b0, acc_q} + {1'b0, opnd_q}
         + {8'h00, flg_q[`BAD_FLG_C]};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]}
         + {4'h0, flg_q[`BAD_FLG_C]};
    res  = sum9[7:0];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Anything not ours is dropped and reported on no_match_out for one cycle; no trap is raised
  always @* begin
    state_d   = state_q;
    mode_d    = mode_q;
    pfx_d     = pfx_q;
    field_d   = field_q;
    lo_d      = lo_q;
    hi_d      = hi_q;
    opnd_d    = opnd_q;
    acc_d     = acc_q;
    flg_d     = flg_q;
    req_d     = req_q;
    addr_d    = addr_q;
    done_d    = 1'b0;
    nomatch_d = 1'b0;
    if (take)
      field_d = byte_in[2:0];
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (byte_in == `BAD_PFX_FIRST || byte_in == `BAD_PFX_SECOND) begin
            pfx_d   = byte_in[`BAD_PFX_SEL_BIT];
            state_d = ST_PREFIX;
          end else if (byte_in[7:3] == `BAD_OPC_MAIN) begin
            if (byte_in[2:0] == `BAD_FLD_MEM) begin
              mode_d  = MD_IND;
              state_d = ST_ADDR;
            end else begin
              mode_d  = MD_REG;
              opnd_d  = reg_val;
              state_d = ST_EXEC;
            end
          end else if (byte_in == `BAD_OPC_IMM) begin
            mode_d  = MD_IMM;
            state_d = ST_OPER1;
          end else begin
            nomatch_d = 1'b1;
          end
        end
      end
      ST_PREFIX: begin
        if (take) begin
          state_d = ST_IDLE;
          if (byte_in[7:3] != `BAD_OPC_MAIN) begin
            nomatch_d = 1'b1;
          end else begin
            case (byte_in[2:0])
              `BAD_FLD_RX_HI, `BAD_FLD_RX_LO: begin
                mode_d  = MD_REG;
                opnd_d  = byte_in[0] ? sel_index[7:0] : sel_index[15:8];
                state_d = ST_EXEC;
              end
              `BAD_FLD_MEM: begin
                mode_d  = MD_SHORT;
                state_d = ST_OPER1;
              end
              `BAD_FLD_DIRECT: begin
                if (!pfx_q) begin
                  mode_d  = MD_DIRECT;
                  state_d = ST_OPER1;
                end else begin
                  nomatch_d = 1'b1;
                end
              end
              `BAD_FLD_REL: begin
                mode_d  = pfx_q ? MD_PCREL : MD_STACK;
                state_d = ST_OPER1;
              end
              default: begin
                if (pfx_q) begin
                  mode_d  = MD_INDEX;
                  state_d = ST_OPER1;
                end else begin
                  mode_d  = MD_BASE;
                  state_d = ST_ADDR;
                end
              end
            endcase
          end
        end
      end
      ST_OPER1: begin
        field_d = field_q;
        if (take) begin
          lo_d = byte_in;
          if (mode_q == MD_IMM) begin
            opnd_d  = byte_in;
            state_d = ST_EXEC;
          end else if (mode_q == MD_SHORT) begin
            state_d = ST_ADDR;
          end else begin
            state_d = ST_OPER2;
          end
        end
      end
      ST_OPER2: begin
        field_d = field_q;
        if (take) begin
          hi_d    = byte_in;
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        req_d   = 1'b1;
        addr_d  = ea;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (mem_rd_valid_in) begin
          req_d   = 1'b0;
          opnd_d  = mem_rd_data_in;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        acc_d = res;
        flg_d = flg_q;
        flg_d[`BAD_FLG_S] = res[7];
        flg_d[`BAD_FLG_Z] = (res == 8'h00);
        flg_d[`BAD_FLG_H] = sum5[4];
        flg_d[`BAD_FLG_V] = (acc_q[7] == opnd_q[7])
                          & (res[7] != acc_q[7]);
        flg_d[`BAD_FLG_N] = 1'b0;
        flg_d[`BAD_FLG_C] = sum9[8];
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        req_d   = 1'b0;
      end
    endcase
    // Core load only lands while no instruction is in flight
    if (acc_load_in && state_q == ST_IDLE) begin
      acc_d = acc_load_data_in;
      flg_d = flags_load_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q   <= ST_IDLE;
      mode_q    <= MD_REG;
      pfx_q     <= 1'b0;
      field_q   <= 3'h0;
      lo_q      <= 8'h00;
      hi_q      <= 8'h00;
      opnd_q    <= 8'h00;
      acc_q     <= `BAD_ACC_RST;
      flg_q     <= `BAD_FLG_RST;
      req_q     <= 1'b0;
      addr_q    <= `BAD_ADDR_RST;
      done_q    <= 1'b0;
      nomatch_q <= 1'b0;
      ready_q   <= 1'b0;
    end else if (clk_en_in) begin
      state_q   <= state_d;
      mode_q    <= mode_d;
      pfx_q     <= pfx_d;
      field_q   <= field_d;
      lo_q      <= lo_d;
      hi_q      <= hi_d;
      opnd_q    <= opnd_d;
      acc_q     <= acc_d;
      flg_q     <= flg_d;
      req_q     <= req_d;
      addr_q    <= addr_d;
      done_q    <= done_d;
      nomatch_q <= nomatch_d;
      // Ready is registered so the fetch side sees a clean level
      ready_q   <= (state_d <= ST_OPER2);
    end
  end

  assign byte_ready_out = ready_q;
  assign mem_rd_req_out = req_q;
  assign mem_addr_out   = addr_q;
  assign acc_out        = acc_q;
  assign flags_out      = flg_q;
  assign done_out       = done_q;
  assign no_match_out   = nomatch_q;

endmodule
